// File: design/plc_regs.sv
// Indicator and transceiver control registers with management access
`timescale 1ns/1ns
module plc_regs #(
	parameter int STRETCH_CYCLES = plc_pkg::STRETCH_CYCLES
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Management register port
	input  wire logic [4:0]  i_mgmt_addr,
	input  wire logic        i_mgmt_wr,
	input  wire logic        i_mgmt_rd,
	input  wire logic [15:0] i_mgmt_wdata,
	output logic [15:0]      o_mgmt_rdata,
	output logic             o_mgmt_rvalid,
	// Strap pin for crossover enable
	input  wire logic        i_auto_crossover_strap,
	// Negotiation results
	input  wire logic [1:0]  i_local_ability_advert,
	input  wire logic [1:0]  i_partner_ability_advert,
	input  wire logic        i_negotiated_full_duplex,
	// Link indicator
	input  wire logic        i_link_indicator_output,
	output logic             o_link_indicator_pin,
	// Crossover controls
	output logic             o_auto_crossover_enable,
	output logic             o_force_pair_crossover,
	// Self-test controls and error report
	input  wire logic        i_selftest_error,
	output logic             o_selftest_run,
	output logic             o_selftest_force_error,
	output logic             o_selftest_sequence_select
);
	// Stored control fields
	logic       ovr_en;
	logic       forced_val;
	logic       auto_x;
	logic       force_x;
	logic       fe;
	logic       seq_sel;
	logic       run;
	logic       run_q;
	logic       status;
	logic       bypass;
	// Strap capture after reset release
	logic       strap_meta;
	logic       strap_sync;
	logic [1:0] strap_cnt;
	logic       strap_done;
	// Resolved pause and stretched indicator
	logic       pause_rx;
	logic       pause_tx;
	logic       stretched;

	// Address decode
	wire hit_led = (i_mgmt_addr == plc_pkg::LED_CTRL_ADDR);
	wire hit_xc = (i_mgmt_addr == plc_pkg::XCVR_CTRL_ADDR);
	wire wr_led = i_mgmt_wr & hit_led;
	wire wr_xc = i_mgmt_wr & hit_xc;
	wire strap_load = ~strap_done & (strap_cnt == plc_pkg::STRAP_LOAD_CNT);

	// Next values of writable fields; only bits 4 and 1 of the indicator register are kept
	wire next_ovr = wr_led ? i_mgmt_wdata[plc_pkg::LED_OVR_BIT] : ovr_en;
	wire next_forced = wr_led ? i_mgmt_wdata[plc_pkg::LED_FORCE_BIT]
		: forced_val;
	wire next_auto_x = wr_xc ? i_mgmt_wdata[plc_pkg::XC_MDIX_BIT] :
		strap_load ? strap_sync : auto_x;
	wire next_force_x = wr_xc ? i_mgmt_wdata[plc_pkg::XC_FORCE_X_BIT]
		: force_x;
	// Force error lives one cycle, so each write with bit 11 set makes exactly one error
	wire next_fe = wr_xc & i_mgmt_wdata[plc_pkg::XC_FE_BIT];
	wire next_seq = wr_xc ? i_mgmt_wdata[plc_pkg::XC_SEQ_BIT]
		: seq_sel;
	wire next_run = wr_xc ? i_mgmt_wdata[plc_pkg::XC_RUN_BIT] : run;
	wire next_bypass = wr_xc ? i_mgmt_wdata[plc_pkg::XC_BYPASS_BIT]
		: bypass;

	// Self-test status: pass at start, error latches fail, stop clears
	wire run_rise = run & ~run_q;
	wire next_status = ~run ? 1'h0 : run_rise ? 1'h1 :
		i_selftest_error ? 1'h0 : status;

	// Indicator source: override wins over the stretched state
	wire next_pin = ovr_en ? forced_val : stretched;

	// Read words; reserved and unmodelled bits read zero
	logic [15:0] led_word;
	logic [15:0] xc_word;
	always_comb begin
		led_word = plc_pkg::REG_RESET;
		led_word[plc_pkg::LED_OVR_BIT] = ovr_en;
		led_word[plc_pkg::LED_FORCE_BIT] = forced_val;
		xc_word = plc_pkg::REG_RESET;
		xc_word[plc_pkg::XC_MDIX_BIT] = auto_x;
		xc_word[plc_pkg::XC_FORCE_X_BIT] = force_x;
		xc_word[plc_pkg::XC_PAUSE_RX_BIT] = pause_rx;
		xc_word[plc_pkg::XC_PAUSE_TX_BIT] = pause_tx;
		xc_word[plc_pkg::XC_FE_BIT] = fe;
		xc_word[plc_pkg::XC_SEQ_BIT] = seq_sel;
		xc_word[plc_pkg::XC_STATUS_BIT] = status;
		xc_word[plc_pkg::XC_RUN_BIT] = run;
		xc_word[plc_pkg::XC_BYPASS_BIT] = bypass;
	end
	// Unmapped addresses answer with zero rather than stale data
	wire [15:0] next_rdata = hit_led ? led_word :
		hit_xc ? xc_word : plc_pkg::REG_RESET;

	// Strap synchroniser; only the second flop is looked at
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			strap_meta <= 1'h0;
			strap_sync <= 1'h0;
		end else begin
			strap_meta <= i_auto_crossover_strap;
			strap_sync <= strap_meta;
		end
	end

	// Wait for the synchroniser to fill, then take the strap once
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			strap_cnt  <= 2'h0;
			strap_done <= 1'h0;
		end else begin
			if (!strap_done && strap_cnt != plc_pkg::STRAP_LOAD_CNT)
				strap_cnt <= strap_cnt + 2'h1;
			if (strap_load)
				strap_done <= 1'h1;
		end
	end

	// Indicator register fields
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ovr_en     <= 1'h0;
			forced_val <= 1'h0;
		end else begin
			ovr_en     <= next_ovr;
			forced_val <= next_forced;
		end
	end

	// Transceiver control fields
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			auto_x  <= 1'h0;
			force_x <= 1'h0;
			fe      <= 1'h0;
			seq_sel <= 1'h0;
			bypass  <= 1'h0;
		end else begin
			auto_x  <= next_auto_x;
			force_x <= next_force_x;
			fe      <= next_fe;
			seq_sel <= next_seq;
			bypass  <= next_bypass;
		end
	end

	// Self-test run and result
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			run    <= 1'h0;
			run_q  <= 1'h0;
			status <= 1'h0;
		end else begin
			run    <= next_run;
			run_q  <= run;
			status <= next_status;
		end
	end

	// Read answer, one cycle after the strobe
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mgmt_rdata  <= plc_pkg::REG_RESET;
			o_mgmt_rvalid <= 1'h0;
		end else begin
			o_mgmt_rvalid <= i_mgmt_rd;
			if (i_mgmt_rd)
				o_mgmt_rdata <= next_rdata;
		end
	end

	// Indicator pin flop
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			o_link_indicator_pin <= 1'h0;
		else
			o_link_indicator_pin <= next_pin;
	end

	// Control outputs are the field flops themselves
	assign o_auto_crossover_enable    = auto_x;
	assign o_force_pair_crossover     = force_x;
	assign o_selftest_run             = run;
	assign o_selftest_force_error     = fe;
	assign o_selftest_sequence_select = seq_sel;

	// Pause resolution from advertised abilities
	plc_pause_resolve u_pause (
		.i_clk         (i_clk),
		.i_rst         (i_rst),
		.i_local_adv   (i_local_ability_advert),
		.i_partner_adv (i_partner_ability_advert),
		.i_full_duplex (i_negotiated_full_duplex),
		.o_pause_rx    (pause_rx),
		.o_pause_tx    (pause_tx)
	);

	// Stretcher for the link indicator
	plc_stretch #(
		.STRETCH_CYCLES (STRETCH_CYCLES)
	) u_stretch (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_raw    (i_link_indicator_output),
		.i_bypass (bypass),
		.o_out    (stretched)
	);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Indicator register: stored bits only, upper bits always zero
	a_upper_zero: assert property (
		i_mgmt_rd && hit_led |=> o_mgmt_rdata[15:6] == 10'h000)
		else $error("indicator register upper bits not zero");
	a_led_store: assert property (
		wr_led |=> ovr_en == $past(i_mgmt_wdata[plc_pkg::LED_OVR_BIT])
		&& forced_val == $past(i_mgmt_wdata[plc_pkg::LED_FORCE_BIT]))
		else $error("indicator register write lost");
	a_override_drive: assert property (
		ovr_en |=> o_link_indicator_pin == $past(forced_val))
		else $error("override value not on indicator pin");
	a_pin_normal: assert property (
		!ovr_en |=> o_link_indicator_pin == $past(stretched))
		else $error("indicator pin not following stretched state");
	a_read_stored: assert property (
		i_mgmt_rd && hit_led && !i_mgmt_wr |=> o_mgmt_rvalid
		&& o_mgmt_rdata[plc_pkg::LED_FORCE_BIT] == $past(forced_val)
		&& o_mgmt_rdata[plc_pkg::LED_OVR_BIT] == $past(ovr_en))
		else $error("indicator read not stored bits");

	// Crossover fields and the strap load at start-up
	a_mdix_write: assert property (
		wr_xc |=> o_auto_crossover_enable
		== $past(i_mgmt_wdata[plc_pkg::XC_MDIX_BIT]))
		else $error("crossover enable write lost");
	a_strap_load: assert property (
		strap_load && !wr_xc |=> auto_x == $past(strap_sync))
		else $error("strap not loaded into crossover enable");
	a_cross_write: assert property (
		wr_xc |=> o_force_pair_crossover
		== $past(i_mgmt_wdata[plc_pkg::XC_FORCE_X_BIT]))
		else $error("force crossover write lost");

	// Back-to-back error writes rightly give one error each
	a_fe_single: assert property (
		o_selftest_force_error
		&& !(wr_xc && i_mgmt_wdata[plc_pkg::XC_FE_BIT])
		|=> !o_selftest_force_error)
		else $error("force error longer than one cycle");
	a_fe_write: assert property (
		wr_xc && i_mgmt_wdata[plc_pkg::XC_FE_BIT]
		|=> o_selftest_force_error)
		else $error("force error not issued");
	a_seq_write: assert property (
		wr_xc |=> o_selftest_sequence_select
		== $past(i_mgmt_wdata[plc_pkg::XC_SEQ_BIT]))
		else $error("sequence select write lost");
	a_run_write: assert property (
		wr_xc |=> o_selftest_run
		== $past(i_mgmt_wdata[plc_pkg::XC_RUN_BIT]))
		else $error("self-test run write lost");
	a_bypass_write: assert property (
		wr_xc |=> bypass
		== $past(i_mgmt_wdata[plc_pkg::XC_BYPASS_BIT]))
		else $error("stretch bypass write lost");

	// Pause status reads the resolved flops, never the write data
	a_pause_read: assert property (
		i_mgmt_rd && hit_xc |=> o_mgmt_rdata[plc_pkg::XC_PAUSE_RX_BIT]
		== $past(pause_rx) && o_mgmt_rdata[plc_pkg::XC_PAUSE_TX_BIT]
		== $past(pause_tx))
		else $error("pause status read wrong");

	// Self-test result: pass at start, fail latched, cleared on stop
	a_fail_latch: assert property (
		run && run_q && !status && !wr_xc |=> !status)
		else $error("self-test fail not latched");
	a_stop_clear: assert property (
		!run |=> !status)
		else $error("status not cleared on stop");
	a_start_pass: assert property (
		run && !run_q ##1 !i_selftest_error && run |=> status)
		else $error("self-test does not start as pass");

	// Main scenarios
	c_override: cover property (wr_led && i_mgmt_wdata[4] ##1 ovr_en);
	c_fail: cover property (run && status ##1 i_selftest_error ##1 !status);
	c_pause: cover property (pause_rx && pause_tx);
	c_strap: cover property (strap_load && strap_sync);
	c_inject: cover property (wr_xc && i_mgmt_wdata[plc_pkg::XC_FE_BIT]
		##1 o_selftest_force_error);
endmodule

// File: design/plc_pkg.sv
// Constants for the indicator and transceiver control register bank
package plc_pkg;
	// Register addresses on the management port
	localparam logic [4:0] LED_CTRL_ADDR = 5'h18;
	localparam logic [4:0] XCVR_CTRL_ADDR = 5'h19;
	// Indicator register fields
	localparam int LED_OVR_BIT = 4;
	localparam int LED_FORCE_BIT = 1;
	// Transceiver control register fields
	localparam int XC_MDIX_BIT = 15;
	localparam int XC_FORCE_X_BIT = 14;
	localparam int XC_PAUSE_RX_BIT = 13;
	localparam int XC_PAUSE_TX_BIT = 12;
	localparam int XC_FE_BIT = 11;
	localparam int XC_SEQ_BIT = 10;
	localparam int XC_STATUS_BIT = 9;
	localparam int XC_RUN_BIT = 8;
	localparam int XC_BYPASS_BIT = 7;
	// Reset values of stored fields and the strap load count
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
	// Indicator stretch time and its cycle count
	localparam int CLK_MHZ = 125;
	localparam int STRETCH_TIME_MS = 50;
	localparam int STRETCH_CYCLES = STRETCH_TIME_MS * CLK_MHZ * 1000;
endpackage

// File: design/plc_pause_resolve.sv
// Pause resolution from local and partner advertised abilities
`timescale 1ns/1ns
module plc_pause_resolve (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Advertised abilities: bit 1 asymmetric, bit 0 pause
	input  wire logic [1:0] i_local_adv,
	input  wire logic [1:0] i_partner_adv,
	input  wire logic       i_full_duplex,
	// Resolved pause enables
	output logic            o_pause_rx,
	output logic            o_pause_tx
);
	// Symmetric and one-way outcomes of the resolution table
	wire both_sym = i_local_adv[0] & i_partner_adv[0];
	wire rx_only = i_local_adv[0] & i_local_adv[1] & ~i_partner_adv[0]
		& i_partner_adv[1];
	wire tx_only = ~i_local_adv[0] & i_local_adv[1] & i_partner_adv[0]
		& i_partner_adv[1];
	wire next_rx = i_full_duplex & (both_sym | rx_only);
	wire next_tx = i_full_duplex & (both_sym | tx_only);

	// Registered so the status bits never glitch during a read
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pause_rx <= 1'h0;
			o_pause_tx <= 1'h0;
		end else begin
			o_pause_rx <= next_rx;
			o_pause_tx <= next_tx;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_pause_halfdup: assert property (
		!i_full_duplex |=> !o_pause_rx && !o_pause_tx)
		else $error("pause set without full duplex");
endmodule

// File: design/plc_stretch.sv
// Pulse stretcher for an indicator, with bypass
`timescale 1ns/1ns
module plc_stretch #(
	parameter int STRETCH_CYCLES = plc_pkg::STRETCH_CYCLES
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Raw indicator state and bypass control
	input  wire logic i_raw,
	input  wire logic i_bypass,
	// Stretched indicator
	output logic      o_out
);
	localparam int CNT_W = $clog2(STRETCH_CYCLES + 1);
	logic [CNT_W-1:0] hold_cnt;

	// Reload while raw is high so short blips stay visible to the eye
	wire [CNT_W-1:0] next_cnt = i_raw ? CNT_W'(STRETCH_CYCLES) :
		(hold_cnt != '0) ? hold_cnt - 1'b1 : hold_cnt;
	wire next_out = i_bypass ? i_raw : (i_raw | (hold_cnt != '0));

	// Counter and output flop
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hold_cnt <= '0;
			o_out    <= 1'h0;
		end else begin
			hold_cnt <= next_cnt;
			o_out    <= next_out;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_bypass_raw: assert property (
		i_bypass |=> o_out == $past(i_raw))
		else $error("bypass does not pass raw state");
endmodule

// File: sim/plc_mgmt_host.sv
// Station management host model driving the register port
`timescale 1ns/1ns
module plc_mgmt_host (
	// Clock and negotiation state
	input  wire logic        i_clk,
	input  wire logic        i_autoneg_en,
	// Register port toward the device
	output logic [4:0]       o_addr,
	output logic             o_wr,
	output logic             o_rd,
	output logic [15:0]      o_wdata,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_rvalid
);
	// Idle bus at time zero
	initial begin
		o_addr = 5'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 16'h0000;
	end
	// Hosts never set must-be-zero bits
	function automatic logic [15:0] clean(input logic [4:0] a,
		input logic [15:0] d);
		logic [15:0] m;
		m = (a == 5'h18) ? 16'hffd2 : 16'hffbf;
		if (a == 5'h19 && !i_autoneg_en) m[15] = 1'b0;
		return d & m;
	endfunction
	// Write: hold strobe and data until the taking edge
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= clean(a, d);
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~clean(a, d); // Released data is not left stale
	endtask
	// Read: answer lands at the taking edge and is sampled 1 ns after it
	task automatic rd(input logic [4:0] a, output logic [15:0] q,
		output logic ok);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1;
		ok = i_rvalid;
		q = i_rdata;
	endtask
endmodule

// File: sim/phy_led_and_control_regs_tb_top.sv
// Self-checking bench for the indicator and transceiver registers
`timescale 1ns/1ns
module phy_led_and_control_regs_tb_top;
	localparam int SC = 8; // Short stretch keeps the run brief
	logic        clk, rst, wr, rd, rvalid, strap, fdx, raw, pin;
	logic        xen, xforce, sterr, run, fe, seq, an_en;
	logic [4:0]  addr;
	logic [1:0]  ladv, padv;
	logic [15:0] wdata, rdata, r16;
	logic [31:0] seed, r;
	int          fail_count, n_checks, xc_st, st;

	plc_mgmt_host u_plc_mgmt_host (.i_clk(clk), .i_autoneg_en(an_en),
		.o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
		.i_rdata(rdata), .i_rvalid(rvalid));
	plc_regs #(.STRETCH_CYCLES(SC)) u_plc_regs (.i_clk(clk), .i_rst(rst),
		.i_mgmt_addr(addr), .i_mgmt_wr(wr), .i_mgmt_rd(rd),
		.i_mgmt_wdata(wdata), .o_mgmt_rdata(rdata), .o_mgmt_rvalid(rvalid),
		.i_auto_crossover_strap(strap), .i_local_ability_advert(ladv),
		.i_partner_ability_advert(padv), .i_negotiated_full_duplex(fdx),
		.i_link_indicator_output(raw), .o_link_indicator_pin(pin),
		.o_auto_crossover_enable(xen), .o_force_pair_crossover(xforce),
		.i_selftest_error(sterr), .o_selftest_run(run),
		.o_selftest_force_error(fe), .o_selftest_sequence_select(seq));

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Xorshift source with a fixed start
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Reference word of the transceiver register, pause from the inputs
	function automatic logic [15:0] xc_word();
		int l, p, rx, tx;
		l = ladv;
		p = padv;
		rx = fdx && ((l % 2 == 1 && p % 2 == 1) || (l == 3 && p == 2));
		tx = fdx && ((l % 2 == 1 && p % 2 == 1) || (l == 2 && p == 3));
		return 16'(xc_st + rx * 8192 + tx * 4096 + st * 512);
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] q;
		logic        ok;
		u_plc_mgmt_host.rd(a, q, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(q, exp);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog sized well above the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end
	// Main sequence
	initial begin
		{rst, strap, an_en} = 3'b111;
		{fdx, raw, sterr, ladv, padv} = 7'h00;
		{fail_count, n_checks, st} = 0;
		seed = 32'h4f4decfd;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk); // Strap has landed by now
		rdc(5'h18, 16'h0000);
		xc_st = 32768;
		rdc(5'h19, xc_word());
		chk({15'h0000, xen}, 16'h0001);
		// Indicator register with random data and raw link state
		for (int i = 0; i < 12; i++) begin
			r = xs();
			@(posedge clk) raw <= r[20];
			u_plc_mgmt_host.wr(5'h18, r[15:0]);
			rdc(5'h18, r[15:0] & 16'h0012);
			if (r[4]) chk({15'h0000, pin}, {15'h0000, r[1]});
		end
		u_plc_mgmt_host.wr(5'h1a, 16'hffff);
		rdc(5'h1a, 16'h0000);
		// Transceiver register with random data, pause inputs idle
		for (int i = 0; i < 10; i++) begin
			r = xs();
			r16 = r[15:0];
			u_plc_mgmt_host.wr(5'h19, r16);
			#1 chk({15'h0000, fe}, {15'h0000, r16[11]});
			@(posedge clk);
			#1 chk({15'h0000, fe}, 16'h0000);
			chk({12'h000, xen, xforce, seq, run},
				{12'h000, r16[15:14], r16[10], r16[8]});
			xc_st = r16 & 16'hc580;
			st = r16[8];
			rdc(5'h19, xc_word());
		end
		// Negotiation off: the host drops crossover enable
		an_en <= 1'b0;
		u_plc_mgmt_host.wr(5'h19, 16'h8000);
		{xc_st, st} = 0;
		rdc(5'h19, xc_word());
		// Every pause advertisement and duplex combination
		for (int k = 0; k < 32; k++) begin
			@(posedge clk) {fdx, ladv, padv} <= 5'(k);
			#1 rdc(5'h19, xc_word());
		end
		// Self-test start, latched failure, stop and restart
		u_plc_mgmt_host.wr(5'h19, 16'h0100);
		xc_st = 256;
		st = 1;
		rdc(5'h19, xc_word());
		@(posedge clk) sterr <= 1'b1;
		@(posedge clk) sterr <= 1'b0;
		st = 0;
		rdc(5'h19, xc_word());
		rdc(5'h19, xc_word());
		u_plc_mgmt_host.wr(5'h19, 16'h0000);
		xc_st = 0;
		rdc(5'h19, xc_word());
		u_plc_mgmt_host.wr(5'h19, 16'h0100);
		xc_st = 256;
		st = 1;
		rdc(5'h19, xc_word());
		// Stretching on and bypassed, override off
		u_plc_mgmt_host.wr(5'h18, 16'h0000);
		@(posedge clk) raw <= 1'b0;
		repeat (12) @(posedge clk);
		for (int b = 0; b < 2; b++) begin
			u_plc_mgmt_host.wr(5'h19, b ? 16'h0080 : 16'h0000);
			@(posedge clk) raw <= 1'b1;
			repeat (3) @(posedge clk);
			raw <= 1'b0;
			repeat (3) @(posedge clk);
			#1 chk({15'h0000, pin}, b ? 16'h0000 : 16'h0001);
			repeat (12) @(posedge clk);
			#1 chk({15'h0000, pin}, 16'h0000);
		end
		results();
	end
endmodule
